// >>> rtl/sfmp_params.svh
`ifndef SFMP_PARAMS_SVH
`define SFMP_PARAMS_SVH

// Register offsets on the special function register bus
`define SFMP_CTRL_ADDR 8'ha9
`define SFMP_DATA_ADDR 8'haa

// Control register fields
`define SFMP_ON_BIT 3
`define SFMP_SOFF_BIT 2
`define SFMP_RATE_MSB 1
`define SFMP_RATE_LSB 0
`define SFMP_CTRL_MASK 8'h0f
`define SFMP_CTRL_RST 8'h00

// Shift geometry
`define SFMP_LAST_BIT 3'h7
`define SFMP_MSB 7

// Serial clock periods in microcontroller clocks, minus one
`define SFMP_LAST_DIV4 5'h03
`define SFMP_LAST_DIV8 5'h07
`define SFMP_LAST_DIV16 5'h0f
`define SFMP_LAST_DIV32 5'h1f

// Half periods in microcontroller clocks
`define SFMP_HALF_DIV4 5'h02
`define SFMP_HALF_DIV8 5'h04
`define SFMP_HALF_DIV16 5'h08
`define SFMP_HALF_DIV32 5'h10

`endif

// >>> rtl/sfmp_pkg.sv
package sfmp_pkg;

    typedef enum logic [0:0] {
        SFMP_IDLE = 1'b0,
        SFMP_SHIFT = 1'b1
    } sfmp_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfmp_sfr_req_t;

    typedef struct packed {
        logic go;
        logic [7:0] data;
    } sfmp_entry_t;

endpackage : sfmp_pkg

// >>> rtl/sfmp_sync.sv
module sfmp_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic pin_i,
    output logic level
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // Accept a change only once the second and third stages agree
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else if (ce) begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;

endmodule : sfmp_sync

// >>> rtl/sfmp_buf2.sv
module sfmp_buf2 (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire sfmp_pkg::sfmp_entry_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output sfmp_pkg::sfmp_entry_t out_data
);

    sfmp_pkg::sfmp_entry_t mem_reg [0:1];
    sfmp_pkg::sfmp_entry_t mem_next [0:1];
    logic rd_ptr_reg;
    logic rd_ptr_next;
    logic wr_ptr_reg;
    logic wr_ptr_next;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic push;
    logic pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else if (ce) begin
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
            rd_ptr_reg <= rd_ptr_next;
            wr_ptr_reg <= wr_ptr_next;
            count_reg <= count_next;
        end
    end

endmodule : sfmp_buf2

// >>> rtl/sfmp_top.sv
`include "sfmp_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Setting the on bit drives serial clock and data outputs low.
// - Writing the data register starts sending that byte with clock pulses.
// - Reading the data register gives eight clock pulses, shifting in a byte.
// - With shift-off set, data accesses give no pulses, output or shifting.
// - With the block off, a data read returns the held byte only.
// - Rate bits pick clock divided by 4, 8, 16 or 32.
// - The block is always master and makes the serial clock itself.
// - A byte lasts up to 256 clocks; stopped clocks halt shifting.
// - Data register is an 8-bit shifter, most significant bit first.
// - First read only loads received data; a second read fetches it.
// - Output and input shift together, one clock before clock falls.
// - At divide by 4, high phase is two clocks, shift mid-phase.
// - Serial period is N clocks, high and low N/2 each.
// - Clock, data out, data in sit on port 4 bits 1, 2, 4; open-drain.
// - SPI mode 0/3 slaves need one extra falling edge first.
module sfmp_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire sfmp_pkg::sfmp_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic data_wr_ready,
    output logic transfer_busy,
    input wire logic port4_latch_bit1,
    input wire logic port4_latch_bit2,
    input wire logic port4_bit1_pin_i,
    output logic port4_bit1_pin_o,
    output logic port4_bit1_pin_oe,
    input wire logic port4_bit2_pin_i,
    output logic port4_bit2_pin_o,
    output logic port4_bit2_pin_oe,
    input wire logic port4_bit4_pin_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Rate decoding

    function automatic logic [4:0] rate_last(input logic [1:0] rate);
        logic [4:0] r;
        r = `SFMP_LAST_DIV4;
        case (rate)
            2'h0: r = `SFMP_LAST_DIV4;
            2'h1: r = `SFMP_LAST_DIV8;
            2'h2: r = `SFMP_LAST_DIV16;
            default: r = `SFMP_LAST_DIV32;
        endcase
        return r;
    endfunction : rate_last

    function automatic logic [4:0] rate_half(input logic [1:0] rate);
        logic [4:0] r;
        r = `SFMP_HALF_DIV4;
        case (rate)
            2'h0: r = `SFMP_HALF_DIV4;
            2'h1: r = `SFMP_HALF_DIV8;
            2'h2: r = `SFMP_HALF_DIV16;
            default: r = `SFMP_HALF_DIV32;
        endcase
        return r;
    endfunction : rate_half

    ////////////////////////////////////////////////////////////////////////////
    // State

    sfmp_pkg::sfmp_state_t state_reg;
    sfmp_pkg::sfmp_state_t state_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [2:0] bit_reg;
    logic [2:0] bit_next;
    logic [1:0] rate_reg;
    logic [1:0] rate_next;
    logic sck_reg;
    logic sck_next;
    logic sdo_reg;
    logic sdo_next;

    logic block_on;
    logic shift_off;
    logic sdi_level;
    logic ctrl_hit;
    logic data_hit;
    logic start;
    logic buf_out_valid;
    logic buf_out_ready;
    logic buf_in_valid;
    sfmp_pkg::sfmp_entry_t buf_in;
    sfmp_pkg::sfmp_entry_t buf_out;

    assign block_on = ctrl_reg[`SFMP_ON_BIT];
    assign shift_off = ctrl_reg[`SFMP_SOFF_BIT];

    // Address decode
    always_comb begin
        ctrl_hit = 1'b0;
        data_hit = 1'b0;
        if (sfr_req.addr == `SFMP_CTRL_ADDR) begin
            ctrl_hit = 1'b1;
        end else if (sfr_req.addr == `SFMP_DATA_ADDR) begin
            data_hit = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input pin and write buffer

    // Three stages and the agree filter cost about four clocks before a data-in
    // change reaches the shifter. At divide by 4 the sampled bit is the one that
    // stood before the last falling edge of the serial clock, so slaves that
    // answer on the falling edge are read at a slower rate.
    sfmp_sync u_sdi_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .pin_i(port4_bit4_pin_i),
        .level(sdi_level)
    );

    // Written bytes wait here while a transfer is running
    assign buf_in_valid = sfr_req.wr && data_hit;
    assign buf_in.data = sfr_req.wdata;
    assign buf_in.go = block_on && !shift_off;
    assign buf_out_ready = (state_reg == sfmp_pkg::SFMP_IDLE);

    sfmp_buf2 u_wr_buf (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(buf_in_valid),
        .in_ready(data_wr_ready),
        .in_data(buf_in),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register access

    always_comb begin
        ctrl_next = ctrl_reg;
        rdata_next = rdata_reg;

        if (sfr_req.wr && ctrl_hit) begin
            ctrl_next = sfr_req.wdata & `SFMP_CTRL_MASK;
        end

        // Read returns the byte held before any new shifting
        if (sfr_req.rd) begin
            if (ctrl_hit) begin
                rdata_next = ctrl_reg;
            end else if (data_hit) begin
                rdata_next = shift_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= `SFMP_CTRL_RST;
            rdata_reg <= 8'h00;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shifter

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        bit_next = bit_reg;
        rate_next = rate_reg;
        start = 1'b0;

        case (state_reg)
            sfmp_pkg::SFMP_IDLE: begin
                if (buf_out_valid) begin
                    shift_next = buf_out.data;
                    start = buf_out.go && block_on;
                end else if (sfr_req.rd && data_hit) begin
                    start = block_on && !shift_off;
                end
                if (start) begin
                    state_next = sfmp_pkg::SFMP_SHIFT;
                    cnt_next = 5'h00;
                    bit_next = 3'h0;
                    rate_next = ctrl_reg[`SFMP_RATE_MSB:`SFMP_RATE_LSB];
                end
            end
            sfmp_pkg::SFMP_SHIFT: begin
                if (!block_on) begin
                    state_next = sfmp_pkg::SFMP_IDLE;
                    cnt_next = 5'h00;
                end else begin
                    cnt_next = cnt_reg + 5'h01;
                    // Both directions move one clock ahead of the falling edge
                    if (cnt_reg == rate_last(rate_reg) - 5'h01) begin
                        shift_next = {shift_reg[6:0], sdi_level};
                    end
                    if (cnt_reg == rate_last(rate_reg)) begin
                        cnt_next = 5'h00;
                        if (bit_reg == `SFMP_LAST_BIT) begin
                            state_next = sfmp_pkg::SFMP_IDLE;
                        end else begin
                            bit_next = bit_reg + 3'h1;
                        end
                    end
                end
            end
            default: begin
                state_next = sfmp_pkg::SFMP_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; a low clock enable freezes everything, halting a transfer

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= sfmp_pkg::SFMP_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 5'h00;
            bit_reg <= 3'h0;
            rate_reg <= 2'h0;
        end else if (ce) begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            rate_reg <= rate_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin stage: levels for the next cycle, low whenever the block idles

    always_comb begin
        sck_next = 1'b0;
        sdo_next = 1'b0;
        // A transfer that ends or aborts drops clock and data together
        if (state_next == sfmp_pkg::SFMP_SHIFT) begin
            sck_next = (cnt_next >= rate_half(rate_next));
            sdo_next = shift_next[`SFMP_MSB];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end else if (ce) begin
            sck_reg <= sck_next;
            sdo_reg <= sdo_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain pins: released while off, so the pull-up holds them high

    logic [1:0] od_bit;
    logic [1:0] od_latch;
    logic [1:0] od_pull;

    // Bit 0 carries the serial clock, bit 1 the serial data
    assign od_bit = {sdo_reg, sck_reg};
    assign od_latch = {port4_latch_bit2, port4_latch_bit1};

    // The alternate output is gated by the general purpose latch; turning the
    // block on pulls both lines low, which gives a slave its extra falling edge
    generate
        for (genvar gi = 0; gi < 2; gi++) begin : g_od
            assign od_pull[gi] = block_on && !(od_bit[gi] && od_latch[gi]);
        end
    endgenerate

    assign port4_bit1_pin_o = 1'b0;
    assign port4_bit1_pin_oe = od_pull[0];
    assign port4_bit2_pin_o = 1'b0;
    assign port4_bit2_pin_oe = od_pull[1];

    assign sfr_rdata = rdata_reg;
    assign transfer_busy = (state_reg == sfmp_pkg::SFMP_SHIFT) || buf_out_valid;

endmodule : sfmp_top

// >>> dv/sfmp_checker.sv
module sfmp_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire sfmp_pkg::sfmp_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic data_wr_ready,
    input wire logic transfer_busy,
    input wire logic port4_bit1_pin_o,
    input wire logic port4_bit1_pin_oe,
    input wire logic port4_bit2_pin_o,
    input wire logic port4_bit2_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic ctrl_wr;
    assign ctrl_wr = ce && sfr_req.wr && sfr_req.addr == 8'ha9;
    AST_ON_LOW: assert property (ctrl_wr && sfr_req.wdata[3] && !transfer_busy
        |=> port4_bit1_pin_oe && port4_bit2_pin_oe) else $error("pins not low after on");
    AST_OFF_FREE: assert property (ctrl_wr && !sfr_req.wdata[3]
        |=> !port4_bit1_pin_oe && !port4_bit2_pin_oe) else $error("pins held after off");
    AST_SPARE_ZERO: assert property (ce && sfr_req.rd && sfr_req.addr == 8'ha9
        |=> sfr_rdata[7:4] == 4'h0) else $error("spare control bits not zero");
    AST_HIGH_MIN: assert property ($fell(port4_bit1_pin_oe) && transfer_busy
        |=> !port4_bit1_pin_oe) else $error("clock high phase too short");
    AST_LOW_MIN: assert property ($rose(port4_bit1_pin_oe) && transfer_busy
        |=> port4_bit1_pin_oe) else $error("clock low phase too short");
    AST_DATA_HOLD: assert property ($fell(port4_bit1_pin_oe) && transfer_busy
        && !$past(sfr_req.wr) |-> $stable(port4_bit2_pin_oe)) else $error("data moved at rise");
    AST_BYTE_BOUND: assert property ($rose(transfer_busy)
        |-> ##[1:300] !transfer_busy) else $error("transfer too long");
    AST_WR_TAKEN: assert property (ce && sfr_req.wr && sfr_req.addr == 8'haa
        && data_wr_ready |=> transfer_busy) else $error("data write not taken");
    AST_OPEN_DRAIN: assert property (!port4_bit1_pin_o && !port4_bit2_pin_o)
        else $error("open drain output driven high");
endmodule : sfmp_checker

bind sfmp_top sfmp_checker chk_u (.clk, .rstn, .ce, .sfr_req, .sfr_rdata, .data_wr_ready,
    .transfer_busy, .port4_bit1_pin_o, .port4_bit1_pin_oe, .port4_bit2_pin_o, .port4_bit2_pin_oe);

// >>> dv/sfmp_flash_model.sv
module sfmp_flash_model (
    input wire logic sck,
    input wire logic sdi,
    input wire logic cs,
    input wire logic [7:0] tx_byte,
    output logic so,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_reg = 8'h00;
    logic armed = 1'b0;
    initial rx_byte = 8'h00;
    // Deselect loads the reply byte; the first falling edge after select only arms
    always @(negedge cs or negedge sck) begin
        if (!cs) begin
            tx_reg <= tx_byte;
            armed <= 1'b0;
        end else begin
            if (armed) tx_reg <= {tx_reg[6:0], 1'b0};
            armed <= 1'b1;
        end
    end
    always @(posedge sck) if (cs) rx_byte <= {rx_byte[6:0], sdi};
    // Until armed, or while deselected, the line shows the inverse of the held bit
    assign so = (cs && armed) ? tx_reg[7] : ~tx_reg[7];
endmodule : sfmp_flash_model

// >>> dv/sfmp_tb_top.sv
module sfmp_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cs = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    sfmp_pkg::sfmp_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata, rx_byte, b;
    logic wr_rdy, busy, ck_o, ck_oe, do_o, do_oe, so;
    wire sck = ck_oe ? ck_o : 1'b1;
    wire sdo = do_oe ? do_o : 1'b1;
    int mismatches = 0;
    int cmp_count = 0;
    int pulses, highs;

    sfmp_top dut_u (.clk, .rstn, .ce(1'b1), .sfr_req, .sfr_rdata, .data_wr_ready(wr_rdy),
        .transfer_busy(busy), .port4_latch_bit1(1'b1), .port4_latch_bit2(1'b1),
        .port4_bit1_pin_i(sck), .port4_bit1_pin_o(ck_o), .port4_bit1_pin_oe(ck_oe),
        .port4_bit2_pin_i(sdo), .port4_bit2_pin_o(do_o), .port4_bit2_pin_oe(do_oe),
        .port4_bit4_pin_i(so));
    sfmp_flash_model flash_u (.sck, .sdi(sdo), .cs, .tx_byte, .so, .rx_byte);

    initial forever #5 clk = ~clk;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(negedge clk);
        sfr_req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge clk);
        sfr_req = '0;
    endtask : bus

    // Counts clock pulses and clock high cycles while busy until idle
    task automatic run_xfer();
        logic prev;
        prev = sck;
        pulses = 0;
        highs = 0;
        for (int i = 0; i < 400 && (i < 3 || busy); i++) begin
            @(negedge clk);
            if (sck && !prev) pulses++;
            if (sck && busy) highs++;
            prev = sck;
        end
    endtask : run_xfer

    task automatic report_and_stop();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        bus(8'ha9, 1'b0, 8'h00);
        chk("ctrl reset", 8'h00, sfr_rdata);
        bus(8'h55, 1'b0, 8'h00);
        chk("unmapped", 8'h00, sfr_rdata);
        cs = 1'b1;
        for (int r = 0; r < 4; r++) begin
            b = 8'h96 ^ 8'(r * 33);
            bus(8'ha9, 1'b1, 8'h08 | 8'(r));
            chk("idle pins", 8'h04, {5'h00, wr_rdy, sck, sdo});
            bus(8'haa, 1'b1, b);
            run_xfer();
            chk("sent byte", b, rx_byte);
            chk("write pulses", 8'h08, pulses[7:0]);
            chk("high cycles", 8'(16 << r), highs[7:0]);
        end
        bus(8'ha9, 1'b0, 8'h00);
        chk("ctrl read", 8'h0b, sfr_rdata);
        tx_byte = 8'h3c;
        cs = 1'b0;
        @(negedge clk);
        cs = 1'b1;
        bus(8'ha9, 1'b1, 8'h03);
        bus(8'ha9, 1'b1, 8'h0b);
        bus(8'haa, 1'b0, 8'h00);
        run_xfer();
        chk("read pulses", 8'h08, pulses[7:0]);
        bus(8'ha9, 1'b1, 8'h0f);
        bus(8'haa, 1'b0, 8'h00);
        chk("read byte", 8'h3c, sfr_rdata);
        run_xfer();
        chk("shift-off pulses", 8'h00, pulses[7:0]);
        bus(8'haa, 1'b1, 8'h5a);
        run_xfer();
        chk("shift-off write pulses", 8'h00, pulses[7:0]);
        bus(8'ha9, 1'b1, 8'h03);
        bus(8'haa, 1'b0, 8'h00);
        chk("off read", 8'h5a, sfr_rdata);
        run_xfer();
        chk("off pulses", 8'h00, pulses[7:0]);
        report_and_stop();
    end
endmodule : sfmp_tb_top
